// file: rtl/cgc_consts.vh
`ifndef CGC_CONSTS_VH
`define CGC_CONSTS_VH

// Register addresses on the byte-wide register port
`define CGC_ADDR_TEMP      8'h02
`define CGC_ADDR_CAC_LO    8'h0E
`define CGC_ADDR_CAC_HI    8'h0F
`define CGC_ADDR_PFC       8'h10
`define CGC_ADDR_FULL_CAPACITY_REFERENCE      8'h11
`define CGC_ADDR_PEAK      8'h12
`define CGC_ADDR_TALLY_LO  8'h2E
`define CGC_ADDR_TALLY_HI  8'h2F

// Read value of unmapped or reserved addresses
`define CGC_READ_NONE      8'h00

// Three-level strap codes: {low_seen, high_seen}
`define CGC_LVL_Z          2'h0
`define CGC_LVL_H          2'h1
`define CGC_LVL_L          2'h2

// Strap pin positions within the strap vectors
`define CGC_PIN_ONE        0
`define CGC_PIN_TWO        1
`define CGC_PIN_THREE      2
`define CGC_PIN_FOUR       3
`define CGC_PIN_FIVE       4
`define CGC_PIN_SIX        5

// Full count high bytes; every full count has a zero low byte
`define CGC_PFC_HH         8'hBC
`define CGC_PFC_HZ         8'hB4
`define CGC_PFC_HL         8'hA9
`define CGC_PFC_ZH         8'h9C
`define CGC_PFC_ZZ         8'h96
`define CGC_PFC_ZL         8'h8D
`define CGC_PFC_LH         8'h7C
`define CGC_PFC_LZ         8'h71
`define CGC_PFC_LL         8'h66

// Scale codes, mVh per count
`define CGC_SCALE_40       2'h0
`define CGC_SCALE_80       2'h1
`define CGC_SCALE_160      2'h2

// Display mode codes
`define CGC_DISP_TWO       2'h0
`define CGC_DISP_FOUR      2'h1
`define CGC_DISP_FIVE      2'h2

// Temperature breakpoints, signed degrees C
`define CGC_TEMP_BP_M10    8'hF6
`define CGC_TEMP_BP_0      8'h00
`define CGC_TEMP_BP_21     8'h15
`define CGC_TEMP_BP_55     8'h37
`define CGC_TEMP_BP_70     8'h46

// Rate breakpoints, rate LSB is C/256
`define CGC_RATE_BP_C80    8'h03
`define CGC_RATE_BP_C25    8'h0A
`define CGC_RATE_BP_C10    8'h19
`define CGC_RATE_BP_C5     8'h33
`define CGC_RATE_BP_C3     8'h55

// Percent divisor and saturation limits
`define CGC_PCT_DIV        23'h000064
`define CGC_CAP_MAX        16'hFFFF
`define CGC_TALLY_MAX      16'hFFFF

`endif

// file: rtl/cgc_eff_table.v
`timescale 1ns/10ps
`include "cgc_consts.vh"

module cgc_eff_table
(
   // Clock and reset
   input  wire       clock,
   input  wire       rst,
   // Lookup keys
   input  wire [1:0] table_sel,
   input  wire [7:0] temp,
   input  wire [7:0] rate,
   // Efficiency in percent
   output reg  [6:0] eff
);

   // Temperature row, nearest lower breakpoint, clamped at the coldest row
   function [2:0] temp_row;
      input [7:0] t;
      begin
         if ($signed(t) >= $signed(`CGC_TEMP_BP_70))
            temp_row = 3'h5;
         else if ($signed(t) >= $signed(`CGC_TEMP_BP_55))
            temp_row = 3'h4;
         else if ($signed(t) >= $signed(`CGC_TEMP_BP_21))
            temp_row = 3'h3;
         else if ($signed(t) >= $signed(`CGC_TEMP_BP_0))
            temp_row = 3'h2;
         else if ($signed(t) >= $signed(`CGC_TEMP_BP_M10))
            temp_row = 3'h1;
         else
            temp_row = 3'h0;
      end
   endfunction

   // Rate column, nearest lower breakpoint
   function [2:0] rate_col;
      input [7:0] r;
      begin
         if (r >= `CGC_RATE_BP_C3)
            rate_col = 3'h5;
         else if (r >= `CGC_RATE_BP_C5)
            rate_col = 3'h4;
         else if (r >= `CGC_RATE_BP_C10)
            rate_col = 3'h3;
         else if (r >= `CGC_RATE_BP_C25)
            rate_col = 3'h2;
         else if (r >= `CGC_RATE_BP_C80)
            rate_col = 3'h1;
         else
            rate_col = 3'h0;
      end
   endfunction

   // Packed rows, byte n is rate column n; mild, strong and high tables
   function [47:0] table_row;
      input [1:0] sel;
      input [2:0] row;
      begin
         case ({sel, row})
            {`CGC_LVL_Z, 3'h0}: table_row = 48'h51555C606361;
            {`CGC_LVL_Z, 3'h1}: table_row = 48'h55595E616262;
            {`CGC_LVL_Z, 3'h2}: table_row = 48'h575A5E616262;
            {`CGC_LVL_Z, 3'h3}: table_row = 48'h595C60626363;
            {`CGC_LVL_Z, 3'h4}: table_row = 48'h5A5D60626363;
            {`CGC_LVL_Z, 3'h5}: table_row = 48'h5A5D60626363;
            {`CGC_LVL_L, 3'h0}: table_row = 48'h323546505557;
            {`CGC_LVL_L, 3'h1}: table_row = 48'h334450585B5D;
            {`CGC_LVL_L, 3'h2}: table_row = 48'h3C4A555B5E60;
            {`CGC_LVL_L, 3'h3}: table_row = 48'h4451595F6163;
            {`CGC_LVL_L, 3'h4}: table_row = 48'h4A555C616364;
            {`CGC_LVL_L, 3'h5}: table_row = 48'h4C565D626465;
            {`CGC_LVL_H, 3'h0}: table_row = 48'h4B53585C5D5C;
            {`CGC_LVL_H, 3'h1}: table_row = 48'h51595D616262;
            {`CGC_LVL_H, 3'h2}: table_row = 48'h545B60636464;
            {`CGC_LVL_H, 3'h3}: table_row = 48'h585F63666868;
            {`CGC_LVL_H, 3'h4}: table_row = 48'h5A6164696A6A;
            {`CGC_LVL_H, 3'h5}: table_row = 48'h5B6265696B6B;
            default:            table_row = 48'h51555C606361;
         endcase
      end
   endfunction

   wire [47:0] row_bits;
   wire [2:0]  col;
   wire [47:0] shifted;

   // Two-axis lookup by temperature and rate breakpoints
   assign row_bits = table_row(table_sel, temp_row(temp));
   assign col      = rate_col(rate);
   assign shifted  = row_bits >> {col, 3'h0};

   // Registered to keep the divider path short
   always @(posedge clock or posedge rst)
   begin
      if (rst)
         eff <= 7'h00;
      else
         eff <= shifted[6:0];
   end

endmodule // cgc_eff_table

// file: rtl/cgc_core.v
`timescale 1ns/10ps
`include "cgc_consts.vh"

// Functional notes
// - Count pulses increment the discharge tally at 2Eh
// - Tally is sixteen bits in full-count units
// - Compensated capacity readable at 0Eh and 0Fh
// - Capacity equals efficiency times full reference minus tally
// - Rate term uses highest rate held all cycle
// - Highest rate readable at address 12h
// - Temperature term follows live temperature, not held
// - Six three-level straps latched at initialization
// - Straps one, two select full count
// - Strap three selects scale 1/40, 1/80, 1/160
// - Full count readable as byte at 10h
// - Full reference is host-writable byte, hardware-stable
// - Strap six high copies full count, else zero
// - Strap four picks one of three tables
// - Lookup by temperature and five rate breakpoints
// - Strap four floating selects mild table
// - Strap four low selects strong table
// - Strap four high selects high table
// - Strap five selects two, four, five segments
// - No counting below minimum discharge threshold
// - Compensation temperature from sensor, readable at 02h
module cgc_core
#(
   parameter TALLY_W = 16,
   parameter REG_W   = 8
)
(
   // Clock and reset
   input  wire               clock,
   input  wire               rst,
   // Strap sensing, one bit per strap pin
   input  wire [5:0]         strap_high_seen,
   input  wire [5:0]         strap_low_seen,
   input  wire               init_req,
   // Discharge front end
   input  wire               count_pulse,
   input  wire               above_min_threshold,
   input  wire [7:0]         rate_sample,
   input  wire [7:0]         temp_reading,
   // Register port
   input  wire [7:0]         reg_addr,
   input  wire               reg_wr,
   input  wire [REG_W-1:0]   reg_wdata,
   input  wire               reg_rd,
   output reg  [REG_W-1:0]   reg_rdata,
   output reg                reg_rd_valid,
   // Latched configuration
   output reg  [1:0]         cfg_scale,
   output reg  [1:0]         cfg_display,
   output reg  [1:0]         cfg_table,
   output wire               init_busy,
   // Capacity result
   output reg  [TALLY_W-1:0] comp_capacity
);

   // Three-level code of one strap pin
   function [1:0] strap_level;
      input hi;
      input lo;
      begin
         if (hi)
            strap_level = `CGC_LVL_H;
         else if (lo)
            strap_level = `CGC_LVL_L;
         else
            strap_level = `CGC_LVL_Z;
      end
   endfunction

   // Full count high byte from straps one and two
   function [7:0] full_count;
      input [1:0] lvl_one;
      input [1:0] lvl_two;
      begin
         case ({lvl_one, lvl_two})
            {`CGC_LVL_H, `CGC_LVL_H}: full_count = `CGC_PFC_HH;
            {`CGC_LVL_H, `CGC_LVL_Z}: full_count = `CGC_PFC_HZ;
            {`CGC_LVL_H, `CGC_LVL_L}: full_count = `CGC_PFC_HL;
            {`CGC_LVL_Z, `CGC_LVL_H}: full_count = `CGC_PFC_ZH;
            {`CGC_LVL_Z, `CGC_LVL_Z}: full_count = `CGC_PFC_ZZ;
            {`CGC_LVL_Z, `CGC_LVL_L}: full_count = `CGC_PFC_ZL;
            {`CGC_LVL_L, `CGC_LVL_H}: full_count = `CGC_PFC_LH;
            {`CGC_LVL_L, `CGC_LVL_Z}: full_count = `CGC_PFC_LZ;
            default:                  full_count = `CGC_PFC_LL;
         endcase
      end
   endfunction

   // Scale code from strap three
   function [1:0] scale_code;
      input [1:0] lvl;
      begin
         case (lvl)
            `CGC_LVL_H: scale_code = `CGC_SCALE_40;
            `CGC_LVL_L: scale_code = `CGC_SCALE_160;
            default:    scale_code = `CGC_SCALE_80;
         endcase
      end
   endfunction

   // Display code from strap five; floating gives five segments
   function [1:0] display_code;
      input [1:0] lvl;
      begin
         case (lvl)
            `CGC_LVL_H: display_code = `CGC_DISP_TWO;
            `CGC_LVL_L: display_code = `CGC_DISP_FOUR;
            default:    display_code = `CGC_DISP_FIVE;
         endcase
      end
   endfunction

   // Strap levels, decoded once
   wire [1:0] lvl_one   = strap_level(strap_high_seen[`CGC_PIN_ONE],
                                      strap_low_seen[`CGC_PIN_ONE]);
   wire [1:0] lvl_two   = strap_level(strap_high_seen[`CGC_PIN_TWO],
                                      strap_low_seen[`CGC_PIN_TWO]);
   wire [1:0] lvl_three = strap_level(strap_high_seen[`CGC_PIN_THREE],
                                      strap_low_seen[`CGC_PIN_THREE]);
   wire [1:0] lvl_four  = strap_level(strap_high_seen[`CGC_PIN_FOUR],
                                      strap_low_seen[`CGC_PIN_FOUR]);
   wire [1:0] lvl_five  = strap_level(strap_high_seen[`CGC_PIN_FIVE],
                                      strap_low_seen[`CGC_PIN_FIVE]);
   wire [1:0] lvl_six   = strap_level(strap_high_seen[`CGC_PIN_SIX],
                                      strap_low_seen[`CGC_PIN_SIX]);

   reg                init_pending;
   reg  [7:0]         programmed_full_reference;
   reg  [7:0]         full_capacity_reference;
   reg  [7:0]         peak_discharge_rate;
   reg  [7:0]         temp_value;
   reg  [TALLY_W-1:0] discharge_tally;
   reg  [TALLY_W-1:0] next_tally;
   reg  [TALLY_W-1:0] next_capacity;
   wire [6:0]         efficiency_factor;
   wire [22:0]        scaled_full;
   wire [22:0]        comp_full;
   wire [TALLY_W-1:0] comp_full_sat;
   wire               wr_tally_lo;
   wire               wr_tally_hi;
   wire               count_ok;

   assign init_busy   = init_pending;
   assign wr_tally_lo = reg_wr && (reg_addr == `CGC_ADDR_TALLY_LO);
   assign wr_tally_hi = reg_wr && (reg_addr == `CGC_ADDR_TALLY_HI);
   // Pulses under the threshold are filtered out
   assign count_ok    = count_pulse && above_min_threshold;

   // Pending flag: set by reset or request, cleared by the capture cycle
   always @(posedge clock or posedge rst)
   begin
      if (rst)
         init_pending <= 1'b1;
      else if (init_req)
         init_pending <= 1'b1;
      else
         init_pending <= 1'b0;
   end

   // Strap capture; straps are sampled only while init is pending so later pin noise is harmless
   always @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         programmed_full_reference <= `CGC_PFC_LL;
         cfg_scale                 <= `CGC_SCALE_80;
         cfg_table                 <= `CGC_LVL_Z;
         cfg_display               <= `CGC_DISP_FIVE;
      end
      else if (init_pending)
      begin
         programmed_full_reference <= full_count(lvl_one, lvl_two);
         cfg_scale                 <= scale_code(lvl_three);
         cfg_table                 <= lvl_four;
         cfg_display               <= display_code(lvl_five);
      end
   end

   // Full reference: loaded at init, otherwise changed only by the host
   always @(posedge clock or posedge rst)
   begin
      if (rst)
         full_capacity_reference <= 8'h00;
      else if (init_pending)
      begin
         if (lvl_six == `CGC_LVL_H)
            full_capacity_reference <= full_count(lvl_one, lvl_two);
         else
            full_capacity_reference <= 8'h00;
      end
      else if (reg_wr && (reg_addr == `CGC_ADDR_FULL_CAPACITY_REFERENCE))
         full_capacity_reference <= reg_wdata;
   end

   // Peak hold, restarted with each discharge cycle at init
   always @(posedge clock or posedge rst)
   begin
      if (rst)
         peak_discharge_rate <= 8'h00;
      else if (init_pending)
         peak_discharge_rate <= 8'h00;
      else if (rate_sample > peak_discharge_rate)
         peak_discharge_rate <= rate_sample;
   end

   // Live temperature, never held across the cycle
   always @(posedge clock or posedge rst)
   begin
      if (rst)
         temp_value <= 8'h00;
      else
         temp_value <= temp_reading;
   end

   // Tally update; a host byte write wins over a count in the same cycle
   always @*
   begin
      next_tally = discharge_tally;
      if (wr_tally_lo)
         next_tally = {discharge_tally[TALLY_W-1:8], reg_wdata};
      else if (wr_tally_hi)
         next_tally = {reg_wdata, discharge_tally[7:0]};
      else if (count_ok && (discharge_tally != `CGC_TALLY_MAX))
         next_tally = discharge_tally + 16'h0001;
   end

   always @(posedge clock or posedge rst)
   begin
      if (rst)
         discharge_tally <= 16'h0000;
      else
         discharge_tally <= next_tally;
   end

   // Efficiency from the latched table, held rate and live temperature
   cgc_eff_table u_eff
   (
      .clock     (clock),
      .rst       (rst),
      .table_sel (cfg_table),
      .temp      (temp_value),
      .rate      (peak_discharge_rate),
      .eff       (efficiency_factor)
   );

   // Percent product on the full reference in counts; divide is a constant
   assign scaled_full   = efficiency_factor * {full_capacity_reference, 8'h00};
   assign comp_full     = scaled_full / `CGC_PCT_DIV;
   // Above-100 percent tables can pass sixteen bits, so clip
   assign comp_full_sat = (comp_full[22:16] != 7'h00) ? `CGC_CAP_MAX : comp_full[15:0];

   // Subtract tally, floored at zero instead of wrapping
   always @*
   begin
      if (discharge_tally >= comp_full_sat)
         next_capacity = 16'h0000;
      else
         next_capacity = comp_full_sat - discharge_tally;
   end

   always @(posedge clock or posedge rst)
   begin
      if (rst)
         comp_capacity <= 16'h0000;
      else
         comp_capacity <= next_capacity;
   end

   // Read path, one cycle latency; reserved addresses read zero
   always @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         reg_rdata    <= `CGC_READ_NONE;
         reg_rd_valid <= 1'b0;
      end
      else
      begin
         reg_rd_valid <= reg_rd;
         if (reg_rd)
         begin
            case (reg_addr)
               `CGC_ADDR_TEMP:     reg_rdata <= temp_value;
               `CGC_ADDR_CAC_LO:   reg_rdata <= comp_capacity[7:0];
               `CGC_ADDR_CAC_HI:   reg_rdata <= comp_capacity[15:8];
               `CGC_ADDR_PFC:      reg_rdata <= programmed_full_reference;
               `CGC_ADDR_FULL_CAPACITY_REFERENCE:     reg_rdata <= full_capacity_reference;
               `CGC_ADDR_PEAK:     reg_rdata <= peak_discharge_rate;
               `CGC_ADDR_TALLY_LO: reg_rdata <= discharge_tally[7:0];
               `CGC_ADDR_TALLY_HI: reg_rdata <= discharge_tally[15:8];
               default:            reg_rdata <= `CGC_READ_NONE;
            endcase
         end
      end
   end

endmodule // cgc_core

// file: test/cgc_chk.sv
`timescale 1ns/10ps
`include "cgc_consts.vh"
module cgc_chk
#(
   parameter TALLY_W = 16,
   parameter REG_W   = 8
)
(
   // Clock and reset
   input wire               clock,
   input wire               rst,
   // Straps and front end
   input wire [5:0]         strap_high_seen,
   input wire [5:0]         strap_low_seen,
   input wire               count_pulse,
   input wire               above_min_threshold,
   input wire [7:0]         rate_sample,
   input wire [7:0]         temp_reading,
   // Register port
   input wire [7:0]         reg_addr,
   input wire               reg_wr,
   input wire [REG_W-1:0]   reg_wdata,
   input wire               reg_rd,
   input wire [REG_W-1:0]   reg_rdata,
   input wire               reg_rd_valid,
   // Results
   input wire [1:0]         cfg_scale,
   input wire [1:0]         cfg_display,
   input wire [1:0]         cfg_table,
   input wire               init_busy,
   input wire [TALLY_W-1:0] comp_capacity
);
   reg [15:0] tly;
   // Strap decode expected now; high wins over low
   wire [1:0] sc = strap_high_seen[2] ? `CGC_SCALE_40 :
                   strap_low_seen[2] ? `CGC_SCALE_160 : `CGC_SCALE_80;
   wire [1:0] dp = strap_high_seen[4] ? `CGC_DISP_TWO :
                   strap_low_seen[4] ? `CGC_DISP_FOUR : `CGC_DISP_FIVE;
   wire [1:0] tb = strap_high_seen[3] ? `CGC_LVL_H :
                   strap_low_seen[3] ? `CGC_LVL_L : `CGC_LVL_Z;
   // Tally mirror; a byte write beats a count in the same cycle
   always @(posedge clock or posedge rst)
   begin
      if (rst)
         tly <= 16'h0000;
      else if (reg_wr && reg_addr == `CGC_ADDR_TALLY_LO)
         tly <= {tly[15:8], reg_wdata};
      else if (reg_wr && reg_addr == `CGC_ADDR_TALLY_HI)
         tly <= {reg_wdata, tly[7:0]};
      else if (count_pulse && above_min_threshold && tly != 16'hFFFF)
         tly <= tly + 16'h0001;
   end
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   sequence s_rd(a);
      reg_rd && reg_addr == a;
   endsequence
   sequence s_rate_held;
      (!init_busy && $stable(rate_sample)) [*3];
   endsequence
   AST_RD_VALID: assert property (reg_rd |=> reg_rd_valid)
      else $error("read gave no valid");
   AST_TEMP: assert property (s_rd(`CGC_ADDR_TEMP) ##0 $stable(temp_reading)
      |=> reg_rdata == $past(temp_reading)) else $error("temperature read wrong");
   AST_TALLY_LO: assert property (s_rd(`CGC_ADDR_TALLY_LO)
      |=> reg_rdata == $past(tly[7:0])) else $error("tally low byte wrong");
   AST_TALLY_HI: assert property (s_rd(`CGC_ADDR_TALLY_HI)
      |=> reg_rdata == $past(tly[15:8])) else $error("tally high byte wrong");
   AST_PEAK: assert property (s_rate_held ##0 s_rd(`CGC_ADDR_PEAK)
      |=> reg_rdata >= $past(rate_sample)) else $error("peak rate below rate");
   AST_CAP_LO: assert property (s_rd(`CGC_ADDR_CAC_LO)
      |=> reg_rdata == $past(comp_capacity[7:0])) else $error("capacity low wrong");
   AST_CAP_HI: assert property (s_rd(`CGC_ADDR_CAC_HI)
      |=> reg_rdata == $past(comp_capacity[15:8])) else $error("capacity high wrong");
   AST_CFG_HOLD: assert property (!init_busy
      |=> $stable({cfg_scale, cfg_display, cfg_table})) else $error("config moved");
   AST_SCALE: assert property (init_busy |=> cfg_scale == $past(sc))
      else $error("scale decode wrong");
   AST_DISP: assert property (init_busy |=> cfg_display == $past(dp))
      else $error("display decode wrong");
   AST_TABLE: assert property (init_busy |=> cfg_table == $past(tb))
      else $error("table decode wrong");
endmodule // cgc_chk

bind cgc_core cgc_chk #(.TALLY_W(TALLY_W), .REG_W(REG_W)) u_cgc_chk
(
   .clock(clock), .rst(rst), .strap_high_seen(strap_high_seen),
   .strap_low_seen(strap_low_seen), .count_pulse(count_pulse),
   .above_min_threshold(above_min_threshold), .rate_sample(rate_sample),
   .temp_reading(temp_reading), .reg_addr(reg_addr), .reg_wr(reg_wr),
   .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .reg_rd_valid(reg_rd_valid), .cfg_scale(cfg_scale), .cfg_display(cfg_display),
   .cfg_table(cfg_table), .init_busy(init_busy), .comp_capacity(comp_capacity)
);

// file: test/cgc_front_model.sv
`timescale 1ns/10ps
module cgc_front_model
(
   // Clock
   input wire        clock,
   // Front-end outputs
   output reg        count_pulse,
   output reg        above_min_threshold,
   output reg  [7:0] rate_sample,
   output reg  [7:0] temp_reading
);
   // Quiet front end at room temperature
   initial
   begin
      count_pulse = 1'b0;
      above_min_threshold = 1'b0;
      rate_sample = 8'h00;
      temp_reading = 8'h15;
   end
   // Gap 0 keeps the pulse high for back-to-back units
   task pulses(input int n, input bit g, input int gap);
      int i;
      begin
         for (i = 0; i < n; i++)
         begin
            @(posedge clock);
            above_min_threshold <= g;
            count_pulse <= 1'b1;
            if (gap > 0)
            begin
               @(posedge clock);
               count_pulse <= 1'b0;
               repeat (gap - 1) @(posedge clock);
            end
         end
         @(posedge clock);
         count_pulse <= 1'b0;
      end
   endtask
   // Rate and temperature move only on an edge
   task env(input [7:0] r, input [7:0] t);
      begin
         @(posedge clock);
         rate_sample <= r;
         temp_reading <= t;
      end
   endtask
endmodule // cgc_front_model

// file: test/testbench.sv
`timescale 1ns/10ps
module testbench;
   reg         clock;
   reg         rst;
   reg  [5:0]  strap_high_seen;
   reg  [5:0]  strap_low_seen;
   reg         init_req;
   reg  [7:0]  reg_addr;
   reg         reg_wr;
   reg  [7:0]  reg_wdata;
   reg         reg_rd;
   wire [7:0]  reg_rdata;
   wire        reg_rd_valid;
   wire [1:0]  cfg_scale;
   wire [1:0]  cfg_display;
   wire [1:0]  cfg_table;
   wire        init_busy;
   wire [15:0] comp_capacity;
   wire        count_pulse;
   wire        above_min_threshold;
   wire [7:0]  rate_sample;
   wire [7:0]  temp_reading;
   int         err_count;
   int         checks;
   int         fc [9] = '{48128, 46080, 43264, 39936, 38400, 36096, 31744, 28928, 26112};
   // Table select, temperature, rate, efficiency percent
   logic [31:0] ec [11] = '{32'h01EC0061, 32'h01EC5551, 32'h01F55455, 32'h01F60362,
      32'h02EC0057, 32'h02EC5532, 32'h02460065, 32'h00EC005C, 32'h0046006B,
      32'h00EC554B, 32'h00151963};
   int         i;
   int         l;
   cgc_core u_cgc_core (.clock(clock), .rst(rst), .strap_high_seen(strap_high_seen),
      .strap_low_seen(strap_low_seen), .init_req(init_req), .count_pulse(count_pulse),
      .above_min_threshold(above_min_threshold), .rate_sample(rate_sample),
      .temp_reading(temp_reading), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .reg_rd_valid(reg_rd_valid), .cfg_scale(cfg_scale), .cfg_display(cfg_display),
      .cfg_table(cfg_table), .init_busy(init_busy), .comp_capacity(comp_capacity));
   cgc_front_model u_cgc_front_model (.clock(clock), .count_pulse(count_pulse),
      .above_min_threshold(above_min_threshold), .rate_sample(rate_sample),
      .temp_reading(temp_reading));
   initial
   begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   task test_done;
      begin
         $display("checks %0d err_count %0d", checks, err_count);
         if (err_count == 0 && checks > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask
   task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      begin
         checks++;
         if (seen !== exp)
         begin
            err_count++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
         end
      end
   endtask
   // Pin levels 0 high, 1 floating, 2 low; result is {low, high}
   function [11:0] st(input int a, b, c, d, e, f);
      int v [6];
      int k;
      begin
         v = '{a, b, c, d, e, f};
         for (k = 0; k < 6; k++)
         begin
            st[k] = (v[k] == 0);
            st[k + 6] = (v[k] == 2);
         end
      end
   endfunction
   task wr(input [7:0] a, input [7:0] d);
      begin
         @(posedge clock);
         reg_addr <= a;
         reg_wdata <= d;
         reg_wr <= 1'b1;
         @(posedge clock);
         reg_wr <= 1'b0;
      end
   endtask
   // Valid is awaited under a bound so a dead port cannot hang the run
   task rc(input [7:0] a, input [7:0] e, input string nm);
      int n;
      begin
         @(posedge clock);
         reg_addr <= a;
         reg_rd <= 1'b1;
         @(posedge clock);
         reg_rd <= 1'b0;
         #1;
         n = 0;
         while (reg_rd_valid !== 1'b1 && n < 4)
         begin
            @(posedge clock);
            #1;
            n++;
         end
         if (reg_rd_valid !== 1'b1)
         begin
            err_count++;
            test_done;
         end
         else
            chk(nm, reg_rdata, e);
      end
   endtask
   task reinit(input [11:0] s);
      begin
         @(posedge clock);
         {strap_low_seen, strap_high_seen} <= s;
         init_req <= 1'b1;
         @(posedge clock);
         init_req <= 1'b0;
         repeat (8) @(posedge clock);
         #1;
         chk("init_busy", init_busy, 16'h0000); // Settled
      end
   endtask
   // Capacity settles within a few edges of any cause
   task capc(input int ef, input int fn, input int ty);
      int v;
      begin
         v = ef * fn * 256 / 100;
         if (v > 65535)
            v = 65535;
         v = (v > ty) ? v - ty : 0;
         repeat (8) @(posedge clock);
         #1;
         chk("comp_capacity", comp_capacity, v[15:0]); // Formula
         rc(8'h0E, v[7:0], "cap_lo"); // Low
         rc(8'h0F, v[15:8], "cap_hi"); // High
      end
   endtask
   initial
   begin
      repeat (100000) @(posedge clock);
      err_count++;
      test_done;
   end
   initial
   begin
      err_count = 0;
      checks = 0;
      rst = 1'b1;
      init_req = 1'b0;
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_wdata = 8'h00;
      reg_rd = 1'b0;
      {strap_low_seen, strap_high_seen} = st(2, 2, 1, 1, 1, 0);
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      repeat (8) @(posedge clock);
      #1;
      chk("scale", cfg_scale, 16'h0001); // Floating
      chk("display", cfg_display, 16'h0002); // Five
      rc(8'h10, 8'h66, "pfc"); // Lowest count
      rc(8'h11, 8'h66, "full_capacity_reference"); // Copied
      rc(8'h02, 8'h15, "temp"); // Sensor
      capc(99, 102, 0); // Mild table
      // Every strap pair, three-level pins cycled alongside
      for (i = 0; i < 9; i++)
      begin
         reinit(st(i / 3, i % 3, i % 3, 1, (i + 1) % 3, (i + 2) % 3));
         l = (i + 1) % 3;
         rc(8'h10, fc[i] >> 8, "pfc"); // Count
         rc(8'h11, ((i + 2) % 3 == 0) ? fc[i] >> 8 : 0, "full_capacity_reference"); // Start
         chk("scale", cfg_scale, i % 3); // Scale
         chk("display", cfg_display, (l == 0) ? 0 : (l == 1) ? 2 : 1); // Mode
      end
      // Table corners and breakpoint edges
      for (i = 0; i < 11; i++)
      begin
         u_cgc_front_model.env(ec[i][15:8], ec[i][23:16]);
         reinit(st(2, 2, 1, ec[i][25:24], 1, 0));
         l = ec[i][25:24];
         chk("table", cfg_table, (l == 0) ? 1 : (l == 1) ? 0 : 2); // Select
         capc(ec[i][7:0], 102, 0); // Lookup
      end
      u_cgc_front_model.env(8'h33, 8'h15);
      capc(95, 102, 0); // Higher rate
      rc(8'h12, 8'h33, "peak"); // Stored
      u_cgc_front_model.env(8'h00, 8'h15);
      capc(95, 102, 0); // Held
      wr(8'h12, 8'hFF);
      rc(8'h12, 8'h33, "peak"); // Read-only
      u_cgc_front_model.env(8'h00, 8'h46);
      capc(98, 102, 0); // Warm
      rc(8'h02, 8'h46, "temp"); // Live
      u_cgc_front_model.env(8'h00, 8'hEC);
      capc(83, 102, 0); // Cold
      // Gated and ungated counting, then saturation
      u_cgc_front_model.pulses(5, 1'b1, 0);
      u_cgc_front_model.pulses(3, 1'b0, 2);
      u_cgc_front_model.pulses(2, 1'b1, 3);
      capc(83, 102, 7); // Drain
      rc(8'h2E, 8'h07, "tally_lo"); // Counted
      rc(8'h2F, 8'h00, "tally_hi"); // Width
      wr(8'h2E, 8'hFE);
      wr(8'h2F, 8'hFF);
      u_cgc_front_model.pulses(3, 1'b1, 0);
      capc(83, 102, 65535); // Floor
      rc(8'h2E, 8'hFF, "tally_lo"); // Top
      rc(8'h03, 8'h00, "unmapped"); // Empty
      wr(8'h10, 8'h00);
      rc(8'h10, 8'h66, "pfc"); // Read-only
      // Zero start; the host supplies the full reference
      reinit(st(2, 2, 1, 0, 1, 2));
      rc(8'h11, 8'h00, "full_capacity_reference"); // Zeroed
      wr(8'h2E, 8'h00);
      wr(8'h2F, 8'h00);
      capc(92, 0, 0); // Empty
      wr(8'h11, 8'h80); // Host load
      u_cgc_front_model.pulses(4, 1'b1, 0);
      capc(92, 128, 4); // New full
      rc(8'h11, 8'h80, "full_capacity_reference"); // Kept
      test_done;
   end
endmodule // testbench
